// ---- core/counter_unit_pkg.sv ----
package counter_unit_pkg;

	// =====================================================================
	// register map, byte addresses on the bus
	localparam logic [15:0] ADDR_CONDITION = 16'h2000; // status rd, ctrl wr
	localparam logic [15:0] ADDR_COUNT     = 16'h2008; // count rd, reload wr
	localparam logic [15:0] ADDR_FIRST     = 16'h200C; // upper rd, cmp0 wr
	localparam logic [15:0] ADDR_SECOND    = 16'h2010; // lower rd, cmp1 wr
	localparam logic [15:0] ADDR_INFIFO    = 16'h2014; // level rd, push wr
	localparam logic [15:0] ADDR_OUTFIFO   = 16'h2018; // pop rd
	localparam logic [15:0] ADDR_OPTIONS   = 16'h201C; // input inversion
	localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

	// =====================================================================
	// condition word bit positions
	localparam int ST_ENABLED        = 31;
	localparam int ST_COUNTING       = 30;
	localparam int ST_BELOW_FIRST    = 29;
	localparam int ST_ATLEAST_FIRST  = 28;
	localparam int ST_ATLEAST_SECOND = 27;
	localparam int ST_RAW_INPUT      = 26;
	localparam int ST_RAW_GATE       = 25;
	localparam int ST_CLEAN_INPUT    = 24;
	localparam int ST_CLEAN_GATE     = 23;
	localparam int ST_INPUT_FALL     = 22;
	localparam int ST_INPUT_RISE     = 21;
	localparam int ST_GATE_FALL      = 20;
	localparam int ST_GATE_RISE      = 19;
	localparam int ST_OUTPUT         = 18;
	localparam int ST_PENDING        = 17;
	localparam int ST_CAP_UPPER      = 16;
	localparam int ST_CAP_LOWER      = 15;
	localparam int ST_IN_EMPTY       = 14;
	localparam int ST_IN_HALF        = 13;
	localparam int ST_IN_FULL        = 12;
	localparam int ST_OUT_EMPTY      = 11;
	localparam int ST_OUT_HALF       = 10;
	localparam int ST_OUT_FULL       = 9;

	// =====================================================================
	// control word bit positions and masks
	localparam int CT_RUN        = 31;
	localparam int CT_FETCH      = 30;
	localparam int CT_WORDS      = 29;
	localparam int CT_GATE_INV   = 28;
	localparam int CT_OUT_INV    = 27;
	localparam int CT_MANUAL_VAL = 26;
	localparam int CT_PUSH       = 25;
	localparam int CT_CLR_IN     = 24;
	localparam int CT_CLR_OUT    = 23;
	localparam int CT_SOFT_RST   = 22;
	localparam int CT_MANUAL_SEL = 21;
	localparam int OPT_INPUT_INV = 0;
	localparam logic [31:0] CTRL_KEEP_MASK = 32'hFE20_0000;

	// =====================================================================
	// fifo geometry
	localparam int FIFO_DEPTH = 8;
	typedef logic [2:0] ptr_t;
	typedef logic [3:0] level_t;
	localparam level_t FIFO_EMPTY = 4'h0;
	localparam level_t FIFO_HALF  = 4'h4;
	localparam level_t FIFO_FULL  = 4'h8;

	// =====================================================================
	// timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int DEBOUNCE_NS   = 160;
	localparam int DEBOUNCE_CYC  =
		(DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRESCALE_NS   = 80;
	localparam int PRESCALE_CYC  =
		(PRESCALE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef logic [2:0] deb_t;
	typedef logic [1:0] pre_t;
	localparam deb_t DEBOUNCE_LAST = deb_t'(DEBOUNCE_CYC - 1);
	localparam pre_t PRESCALE_LAST = pre_t'(PRESCALE_CYC - 1);

	// =====================================================================
	// carriers
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [15:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_s;

	typedef struct packed {
		logic [FIFO_DEPTH-1:0][31:0] mem;
		ptr_t                        wp;
		ptr_t                        rp;
		level_t                      level;
	} fifo_s;

	typedef struct packed {
		logic [31:0] ctrl;
		logic        input_invert;
		logic [31:0] count_value;
		logic [31:0] reload_value;
		logic [31:0] compare_first;
		logic [31:0] compare_second;
		logic [31:0] capture_upper;
		logic [31:0] capture_lower;
		logic        upper_avail;
		logic        lower_avail;
		pre_t        prescale;
		deb_t        input_deb;
		deb_t        gate_deb;
		logic        clean_input_level;
		logic        clean_gate_level;
		logic        prev_input;
		logic        prev_gate;
		logic        input_fall_seen;
		logic        input_rise_seen;
		logic        gate_fall_seen;
		logic        gate_rise_seen;
		logic        out_gen;
		logic        output_level;
		logic        counting;
		logic        request_pending;
		fifo_s       infifo;
		fifo_s       outfifo;
		logic        ack;
		logic [31:0] rdata;
	} unit_s;

endpackage

// ---- core/counter_unit_status_control.sv ----
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps

module counter_unit_status_control (
	input  wire logic                      clk_i,
	input  wire logic                      resetn_i,
	input  wire counter_unit_pkg::wb_req_s wb_req_i,
	output counter_unit_pkg::wb_rsp_s      wb_rsp_o,
	input  wire logic                      input_pin_i,
	input  wire logic                      gate_pin_i,
	output logic                           output_pin_o
);

	// =====================================================================
	// helpers
	function automatic logic addr_hit(input logic [15:0] adr,
		input logic [15:0] off);
		return adr[15:2] == off[15:2];
	endfunction

	function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] sel);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = new_w[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic counter_unit_pkg::fifo_s fifo_push(
		input counter_unit_pkg::fifo_s f, input logic [31:0] w);
		counter_unit_pkg::fifo_s r;
		r = f;
		if (f.level != counter_unit_pkg::FIFO_FULL) begin
			r.mem[f.wp] = w;
			r.wp = f.wp + 3'h1;
			r.level = f.level + 4'h1;
		end
		return r;
	endfunction

	function automatic counter_unit_pkg::fifo_s fifo_pop(
		input counter_unit_pkg::fifo_s f);
		counter_unit_pkg::fifo_s r;
		r = f;
		if (f.level != counter_unit_pkg::FIFO_EMPTY) begin
			r.rp = f.rp + 3'h1;
			r.level = f.level - 4'h1;
		end
		return r;
	endfunction

	// =====================================================================
	// state and bus decode
	counter_unit_pkg::unit_s q;
	counter_unit_pkg::unit_s n;
	logic                    take;
	logic                    wr;
	logic                    rd;
	logic                    tick;
	logic                    eoc;
	logic                    in_level;
	logic                    gt_level;
	logic [31:0]             strobes;
	logic [31:0]             status_word;
	logic [31:0]             read_word;

	// one request per ack, ack drops the cycle after it rose
	assign take = wb_req_i.cyc & wb_req_i.stb & ~q.ack;
	assign wr = take & wb_req_i.we;
	assign rd = take & ~wb_req_i.we;
	assign strobes = (wr && addr_hit(wb_req_i.adr,
		counter_unit_pkg::ADDR_CONDITION)) ?
		lane_merge(counter_unit_pkg::ZERO_WORD, wb_req_i.dat,
		wb_req_i.sel) : counter_unit_pkg::ZERO_WORD;

	// pin inversion ahead of the debouncers, prescaled count tick
	assign in_level = input_pin_i ^ q.input_invert;
	assign gt_level = gate_pin_i ^ q.ctrl[counter_unit_pkg::CT_GATE_INV];
	assign tick = q.ctrl[counter_unit_pkg::CT_RUN] &&
		q.prescale == counter_unit_pkg::PRESCALE_LAST;
	assign eoc = tick && q.counting && q.count_value == q.compare_first;

	// live condition word, unlisted bits stay zero
	always_comb begin
		status_word = counter_unit_pkg::ZERO_WORD;
		status_word[counter_unit_pkg::ST_ENABLED] =
			q.ctrl[counter_unit_pkg::CT_RUN];
		status_word[counter_unit_pkg::ST_COUNTING] = q.counting;
		status_word[counter_unit_pkg::ST_BELOW_FIRST] =
			q.count_value < q.compare_first;
		status_word[counter_unit_pkg::ST_ATLEAST_FIRST] =
			q.count_value >= q.compare_first;
		status_word[counter_unit_pkg::ST_ATLEAST_SECOND] =
			q.count_value >= q.compare_second;
		status_word[counter_unit_pkg::ST_RAW_INPUT] = input_pin_i;
		status_word[counter_unit_pkg::ST_RAW_GATE] = gate_pin_i;
		status_word[counter_unit_pkg::ST_CLEAN_INPUT] =
			q.clean_input_level;
		status_word[counter_unit_pkg::ST_CLEAN_GATE] =
			q.clean_gate_level;
		status_word[counter_unit_pkg::ST_INPUT_FALL] = q.input_fall_seen;
		status_word[counter_unit_pkg::ST_INPUT_RISE] = q.input_rise_seen;
		status_word[counter_unit_pkg::ST_GATE_FALL] = q.gate_fall_seen;
		status_word[counter_unit_pkg::ST_GATE_RISE] = q.gate_rise_seen;
		status_word[counter_unit_pkg::ST_OUTPUT] = q.output_level;
		status_word[counter_unit_pkg::ST_PENDING] = q.request_pending;
		status_word[counter_unit_pkg::ST_CAP_UPPER] = q.upper_avail;
		status_word[counter_unit_pkg::ST_CAP_LOWER] = q.lower_avail;
		status_word[counter_unit_pkg::ST_IN_EMPTY] =
			q.infifo.level == counter_unit_pkg::FIFO_EMPTY;
		status_word[counter_unit_pkg::ST_IN_HALF] =
			q.infifo.level >= counter_unit_pkg::FIFO_HALF;
		status_word[counter_unit_pkg::ST_IN_FULL] =
			q.infifo.level == counter_unit_pkg::FIFO_FULL;
		status_word[counter_unit_pkg::ST_OUT_EMPTY] =
			q.outfifo.level == counter_unit_pkg::FIFO_EMPTY;
		status_word[counter_unit_pkg::ST_OUT_HALF] =
			q.outfifo.level >= counter_unit_pkg::FIFO_HALF;
		status_word[counter_unit_pkg::ST_OUT_FULL] =
			q.outfifo.level == counter_unit_pkg::FIFO_FULL;
	end

	// read multiplexer, unmapped reads return zero
	always_comb begin
		read_word = counter_unit_pkg::ZERO_WORD;
		if (addr_hit(wb_req_i.adr, counter_unit_pkg::ADDR_CONDITION)) begin
			read_word = status_word;
		end else if (addr_hit(wb_req_i.adr,
			counter_unit_pkg::ADDR_COUNT)) begin
			read_word = q.count_value;
		end else if (addr_hit(wb_req_i.adr,
			counter_unit_pkg::ADDR_FIRST)) begin
			read_word = q.capture_upper;
		end else if (addr_hit(wb_req_i.adr,
			counter_unit_pkg::ADDR_SECOND)) begin
			read_word = q.capture_lower;
		end else if (addr_hit(wb_req_i.adr,
			counter_unit_pkg::ADDR_INFIFO)) begin
			read_word = {28'h0000000, q.infifo.level};
		end else if (addr_hit(wb_req_i.adr,
			counter_unit_pkg::ADDR_OUTFIFO)) begin
			if (q.outfifo.level != counter_unit_pkg::FIFO_EMPTY) begin
				read_word = q.outfifo.mem[q.outfifo.rp];
			end
		end else if (addr_hit(wb_req_i.adr,
			counter_unit_pkg::ADDR_OPTIONS)) begin
			read_word[counter_unit_pkg::OPT_INPUT_INV] = q.input_invert;
		end
	end

	// =====================================================================
	// next state
	always_comb begin
		n = q;
		n.ack = take;
		n.rdata = rd ? read_word : counter_unit_pkg::ZERO_WORD;
		// read side effects first so a same-cycle event still sets
		if (rd && addr_hit(wb_req_i.adr,
			counter_unit_pkg::ADDR_CONDITION)) begin
			n.input_fall_seen = 1'b0;
			n.input_rise_seen = 1'b0;
			n.gate_fall_seen = 1'b0;
			n.gate_rise_seen = 1'b0;
			n.request_pending = 1'b0;
		end
		if (rd && addr_hit(wb_req_i.adr, counter_unit_pkg::ADDR_FIRST)) begin
			n.upper_avail = 1'b0;
		end
		if (rd && addr_hit(wb_req_i.adr,
			counter_unit_pkg::ADDR_SECOND)) begin
			n.lower_avail = 1'b0;
		end
		if (rd && addr_hit(wb_req_i.adr,
			counter_unit_pkg::ADDR_OUTFIFO)) begin
			n.outfifo = fifo_pop(q.outfifo);
		end
		// edge flags on the pins, set wins over the read clear
		n.prev_input = input_pin_i;
		n.prev_gate = gate_pin_i;
		if (q.prev_input && !input_pin_i) begin
			n.input_fall_seen = 1'b1;
		end
		if (!q.prev_input && input_pin_i) begin
			n.input_rise_seen = 1'b1;
		end
		if (q.prev_gate && !gate_pin_i) begin
			n.gate_fall_seen = 1'b1;
		end
		if (!q.prev_gate && gate_pin_i) begin
			n.gate_rise_seen = 1'b1;
		end
		// prescaler, debouncers and count run only while enabled
		if (q.ctrl[counter_unit_pkg::CT_RUN]) begin
			n.prescale = tick ? 2'h0 : q.prescale + 2'h1;
			n.input_deb = 3'h0;
			n.gate_deb = 3'h0;
			if (in_level != q.clean_input_level) begin
				n.input_deb = q.input_deb + 3'h1;
				if (q.input_deb == counter_unit_pkg::DEBOUNCE_LAST) begin
					n.clean_input_level = in_level;
					n.input_deb = 3'h0;
				end
			end
			if (gt_level != q.clean_gate_level) begin
				n.gate_deb = q.gate_deb + 3'h1;
				if (q.gate_deb == counter_unit_pkg::DEBOUNCE_LAST) begin
					n.clean_gate_level = gt_level;
					n.gate_deb = 3'h0;
				end
			end
			if (tick && q.counting) begin
				n.count_value = q.count_value + 32'h0000_0001;
			end
		end
		// debounced edges capture the count value
		if (n.clean_input_level && !q.clean_input_level) begin
			n.capture_upper = q.count_value;
			n.upper_avail = 1'b1;
		end
		if (!n.clean_input_level && q.clean_input_level) begin
			n.capture_lower = q.count_value;
			n.lower_avail = 1'b1;
		end
		// end of count: reload, fetch, push, toggle, request
		if (eoc) begin
			n.count_value = q.reload_value;
			n.counting = q.ctrl[counter_unit_pkg::CT_FETCH];
			n.out_gen = ~q.out_gen;
			n.request_pending = 1'b1;
			if (q.ctrl[counter_unit_pkg::CT_FETCH] &&
				n.infifo.level != counter_unit_pkg::FIFO_EMPTY) begin
				n.compare_first = n.infifo.mem[n.infifo.rp];
				n.infifo = fifo_pop(n.infifo);
				if (q.ctrl[counter_unit_pkg::CT_WORDS] &&
					n.infifo.level != counter_unit_pkg::FIFO_EMPTY) begin
					n.compare_second = n.infifo.mem[n.infifo.rp];
					n.infifo = fifo_pop(n.infifo);
				end
			end
			if (q.ctrl[counter_unit_pkg::CT_PUSH]) begin
				if (q.upper_avail && q.lower_avail) begin
					n.outfifo = fifo_push(n.outfifo, q.capture_upper);
					n.outfifo = fifo_push(n.outfifo, q.capture_lower);
					n.upper_avail = 1'b0;
					n.lower_avail = 1'b0;
				end else begin
					n.outfifo = fifo_push(n.outfifo, q.count_value);
				end
			end
		end
		// disabled pin holds or follows the manual value
		if (!q.ctrl[counter_unit_pkg::CT_RUN] &&
			q.ctrl[counter_unit_pkg::CT_MANUAL_SEL]) begin
			n.out_gen = q.ctrl[counter_unit_pkg::CT_MANUAL_VAL];
		end
		// register writes
		if (wr) begin
			if (addr_hit(wb_req_i.adr, counter_unit_pkg::ADDR_CONDITION))
			begin
				n.ctrl = lane_merge(q.ctrl, wb_req_i.dat, wb_req_i.sel) &
					counter_unit_pkg::CTRL_KEEP_MASK;
				if (n.ctrl[counter_unit_pkg::CT_RUN] &&
					!q.ctrl[counter_unit_pkg::CT_RUN]) begin
					n.counting = 1'b1;
				end
			end else if (addr_hit(wb_req_i.adr,
				counter_unit_pkg::ADDR_COUNT)) begin
				n.reload_value = lane_merge(q.reload_value, wb_req_i.dat,
					wb_req_i.sel);
				n.count_value = n.reload_value;
				n.counting = 1'b1;
			end else if (addr_hit(wb_req_i.adr,
				counter_unit_pkg::ADDR_FIRST)) begin
				n.compare_first = lane_merge(q.compare_first,
					wb_req_i.dat, wb_req_i.sel);
			end else if (addr_hit(wb_req_i.adr,
				counter_unit_pkg::ADDR_SECOND)) begin
				n.compare_second = lane_merge(q.compare_second,
					wb_req_i.dat, wb_req_i.sel);
			end else if (addr_hit(wb_req_i.adr,
				counter_unit_pkg::ADDR_INFIFO)) begin
				n.infifo = fifo_push(n.infifo, wb_req_i.dat);
			end else if (addr_hit(wb_req_i.adr,
				counter_unit_pkg::ADDR_OPTIONS) && wb_req_i.sel[0]) begin
				n.input_invert =
					wb_req_i.dat[counter_unit_pkg::OPT_INPUT_INV];
			end
		end
		// path clears and soft reset from control write strobes
		if (strobes[counter_unit_pkg::CT_CLR_IN]) begin
			n.infifo = '0;
			n.capture_upper = counter_unit_pkg::ZERO_WORD;
			n.capture_lower = counter_unit_pkg::ZERO_WORD;
			n.upper_avail = 1'b0;
			n.lower_avail = 1'b0;
		end
		if (strobes[counter_unit_pkg::CT_CLR_OUT]) begin
			n.outfifo = '0;
			n.compare_first = counter_unit_pkg::ZERO_WORD;
			n.compare_second = counter_unit_pkg::ZERO_WORD;
			n.reload_value = counter_unit_pkg::ZERO_WORD;
		end
		if (strobes[counter_unit_pkg::CT_SOFT_RST]) begin
			n = '0;
			n.ack = take;
			n.rdata = counter_unit_pkg::ZERO_WORD;
			n.prev_input = input_pin_i; // no false edge after soft reset
			n.prev_gate = gate_pin_i;
		end
		// inversion is the last stage before the pin
		n.output_level = n.out_gen ^
			n.ctrl[counter_unit_pkg::CT_OUT_INV];
	end

	// state register
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// outputs straight from flops
	assign wb_rsp_o.ack = q.ack;
	assign wb_rsp_o.dat = q.rdata;
	assign output_pin_o = q.output_level;

	// =====================================================================
	// assertions
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	a_enabled_status_read: assert property (
		rd && addr_hit(wb_req_i.adr, counter_unit_pkg::ADDR_CONDITION)
		|=> wb_rsp_o.ack && wb_rsp_o.dat[counter_unit_pkg::ST_ENABLED] ==
		$past(q.ctrl[counter_unit_pkg::CT_RUN]))
		else $error("enabled bit does not follow run enable");

	a_count_frozen: assert property (
		!q.ctrl[counter_unit_pkg::CT_RUN] && !wr |=> $stable(q.count_value))
		else $error("count moved while disabled");

	a_reload_copies_count: assert property (
		wr && addr_hit(wb_req_i.adr, counter_unit_pkg::ADDR_COUNT) &&
		wb_req_i.sel == 4'hF |=> q.count_value == $past(wb_req_i.dat) &&
		q.reload_value == $past(wb_req_i.dat))
		else $error("reload write not copied to count");

	a_input_rise_flag: assert property (
		!q.prev_input && input_pin_i && !strobes[counter_unit_pkg::CT_SOFT_RST]
		|=> q.input_rise_seen)
		else $error("input rise not latched");

	a_status_read_clears: assert property (
		rd && addr_hit(wb_req_i.adr, counter_unit_pkg::ADDR_CONDITION) &&
		input_pin_i == q.prev_input |=> !q.input_rise_seen &&
		!q.input_fall_seen ##1 !wb_rsp_o.ack)
		else $error("edge flags survive a status read");

	a_clear_input_path: assert property (
		strobes[counter_unit_pkg::CT_CLR_IN] |=> q.infifo.level ==
		counter_unit_pkg::FIFO_EMPTY && q.capture_upper == 32'h0000_0000 &&
		q.capture_lower == 32'h0000_0000)
		else $error("input path not cleared");

	a_clear_output_path: assert property (
		strobes[counter_unit_pkg::CT_CLR_OUT] |=> q.outfifo.level ==
		counter_unit_pkg::FIFO_EMPTY && q.reload_value == 32'h0000_0000 &&
		q.compare_first == 32'h0000_0000)
		else $error("output path not cleared");

	a_soft_reset_all: assert property (
		strobes[counter_unit_pkg::CT_SOFT_RST] |=> q.ctrl == 32'h0000_0000 &&
		q.count_value == 32'h0000_0000 && !output_pin_o)
		else $error("soft reset left state behind");

	a_fetch_to_first: assert property (
		eoc && q.ctrl[counter_unit_pkg::CT_FETCH] && !wr &&
		q.infifo.level != counter_unit_pkg::FIFO_EMPTY
		|=> q.compare_first == $past(q.infifo.mem[q.infifo.rp]))
		else $error("fifo word not fetched into compare");

	a_manual_pin_follow: assert property (
		!q.ctrl[counter_unit_pkg::CT_RUN] &&
		q.ctrl[counter_unit_pkg::CT_MANUAL_SEL] && !wr
		|=> output_pin_o ==
		($past(q.ctrl[counter_unit_pkg::CT_MANUAL_VAL]) ^
		$past(q.ctrl[counter_unit_pkg::CT_OUT_INV])))
		else $error("manual pin value not driven");

	a_pin_holds: assert property (
		!q.ctrl[counter_unit_pkg::CT_RUN] &&
		!q.ctrl[counter_unit_pkg::CT_MANUAL_SEL] && !wr |=> $stable(q.out_gen))
		else $error("disabled pin did not hold");

endmodule

// ---- verification/pin_model.sv ----
`timescale 1ns/1ps

// =====================================
// far side: input and gate pin drivers
module pin_model (
	input  wire logic clk_i,
	input  wire logic resetn_i,
	input  wire logic input_want_i,
	input  wire logic gate_want_i,
	output logic      input_pin_o,
	output logic      gate_pin_o
);
	// pins move just after a rising edge
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			input_pin_o <= 1'b0;
			gate_pin_o  <= 1'b0;
		end else begin
			input_pin_o <= input_want_i;
			gate_pin_o  <= gate_want_i;
		end
	end
endmodule

// ---- verification/counter_unit_status_control_tb.sv ----
`timescale 1ns/1ps

// =====================================
// status and control bench
module counter_unit_status_control_tb;
	localparam logic [15:0] CA = counter_unit_pkg::ADDR_CONDITION;
	logic                      clk_i     = 1'b0;
	logic                      resetn_i  = 1'b0;
	logic                      in_w      = 1'b0;
	logic                      gt_w      = 1'b0;
	logic                      in_p;
	logic                      gt_p;
	logic                      out_p;
	logic                      g;
	counter_unit_pkg::wb_req_s req       = '0;
	counter_unit_pkg::wb_rsp_s rsp;
	logic [31:0]               eq[$];
	logic [31:0]               mq[$];
	logic [31:0]               e;
	logic [31:0]               m;
	logic [31:0]               x;
	logic [31:0]               y;
	int                        error_cnt = 0;
	int                        checked   = 0;
	int                        cyc_n     = 0;

	// 25 MHz clock
	always #20 clk_i = ~clk_i;

	pin_model pins (.clk_i(clk_i), .resetn_i(resetn_i),
		.input_want_i(in_w), .gate_want_i(gt_w),
		.input_pin_o(in_p), .gate_pin_o(gt_p));

	counter_unit_status_control dut (.clk_i(clk_i), .resetn_i(resetn_i),
		.wb_req_i(req), .wb_rsp_o(rsp), .input_pin_i(in_p),
		.gate_pin_i(gt_p), .output_pin_o(out_p));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task results;
		if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// classic cycle; reads note the expected word and mask
	task wb(input logic w, input logic [15:0] a, input logic [31:0] d,
		input logic [31:0] ex, input logic [31:0] mk);
		if (!w) begin
			eq.push_back(ex);
			mq.push_back(mk);
		end
		req <= '{1'b1, 1'b1, w, a, 4'hF, d};
		@(posedge clk_i);
		while (rsp.ack !== 1'b1) @(posedge clk_i);
		req <= '0;
		@(posedge clk_i);
	endtask

	// read answers are matched against the oldest note
	always @(posedge clk_i) begin
		if (rsp.ack === 1'b1 && req.we === 1'b0) begin
			e = eq.pop_front();
			m = mq.pop_front();
			chk(rsp.dat & m, e);
		end
	end

	// hang guard
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 3000) begin
			error_cnt++;
			results();
		end
	end

	// main sequence
	initial begin
		void'($urandom(38501));
		g = 1'($urandom);
		x = 32'h1C20_4800 | (g ? 32'h0208_0000 : 32'h0);
		y = 32'h1C00_4800 | (g ? 32'h0200_0000 : 32'h0);
		repeat (10) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		wb(0, CA, 0, 32'h1800_4800, '1);
		in_w <= 1'b1;
		gt_w <= g;
		repeat (3) @(posedge clk_i);
		wb(0, CA, 0, x, '1);
		wb(0, CA, 0, y, '1);
		wb(1, CA, 32'h0420_0000, 0, 0);
		wb(0, CA, 0, 32'h0004_0000, 32'h0004_0000);
		wb(1, CA, 32'h0C20_0000, 0, 0);
		wb(0, CA, 0, 32'h0, 32'h0004_0000);
		chk({31'h0, out_p}, 32'h0);
		wb(1, CA, 32'h0040_0000, 0, 0);
		wb(0, CA, 0, y, '1);
		wb(1, counter_unit_pkg::ADDR_FIRST, 32'h0000_0100, 0, 0);
		wb(1, counter_unit_pkg::ADDR_COUNT, 32'h0, 0, 0);
		wb(1, CA, 32'h8000_0000, 0, 0);
		wb(0, CA, 0, 32'hE800_0000, 32'hF800_0000);
		for (int i = 0; i < 9; i++) begin
			wb(1, counter_unit_pkg::ADDR_INFIFO, $urandom, 0, 0);
			if (i == 3) wb(0, CA, 0, 32'h2000, 32'h7000);
		end
		wb(0, CA, 0, 32'h3000, 32'h7000);
		wb(0, counter_unit_pkg::ADDR_INFIFO, 0, 32'h8, '1);
		wb(1, CA, 32'h0100_0000, 0, 0);
		wb(0, CA, 0, 32'h4000, 32'h7000);
		wb(0, 16'h2004, 0, 32'h0, '1);
		// inverted input, two-word fetch and push at one end of count
		wb(1, counter_unit_pkg::ADDR_OPTIONS, 32'h1, 0, 0);
		wb(0, counter_unit_pkg::ADDR_OPTIONS, 0, 32'h1, '1);
		x = $urandom | 32'h1000_0000;
		y = $urandom | 32'h1000_0000;
		wb(1, counter_unit_pkg::ADDR_INFIFO, x, 0, 0);
		wb(1, counter_unit_pkg::ADDR_INFIFO, y, 0, 0);
		wb(1, counter_unit_pkg::ADDR_FIRST, 32'h0000_0010, 0, 0);
		wb(1, counter_unit_pkg::ADDR_COUNT, 32'h0, 0, 0);
		wb(1, CA, 32'hE200_0000, 0, 0);
		repeat (60) @(posedge clk_i);
		wb(0, counter_unit_pkg::ADDR_OUTFIFO, 0, 32'h10, '1);
		wb(0, CA, 0, 32'hE002_C800, 32'hE903_C800);
		repeat (2) @(posedge clk_i);
		results();
	end
endmodule
